// ===== verilog/ccpc_pkg.sv
// constants shared by the codec clock path register bank and its controller
package ccpc_pkg;

    // ========================================================
    // register link
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam logic [6:0] REG_PAGE_SELECT = 7'h00;
    localparam logic [6:0] REG_PLL_FRACTION_HIGH = 7'h05;
    localparam logic [6:0] REG_PLL_FRACTION_LOW = 7'h06;
    localparam logic [6:0] REG_CODEC_DATAPATH_SETUP = 7'h07;
    localparam logic [6:0] REG_SERIAL_PORT_CONTROL_A = 7'h08;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ========================================================
    // field positions
    localparam int unsigned FRAC_W = 14;
    localparam int unsigned FRAC_LOW_LSB = 2;
    localparam logic [13:0] FRAC_MAX = 14'h270f;
    localparam int unsigned DP_REF_RATE_BIT = 7;
    localparam int unsigned DP_ADC_DUAL_BIT = 6;
    localparam int unsigned DP_DAC_DUAL_BIT = 5;
    localparam int unsigned DP_LEFT_LSB = 3;
    localparam int unsigned DP_RIGHT_LSB = 1;
    localparam int unsigned DP_RESV_BIT = 0;
    localparam int unsigned SP_BCLK_DIR_BIT = 7;
    localparam int unsigned SP_WCLK_DIR_BIT = 6;
    localparam int unsigned SP_DOUT_TRI_BIT = 5;
    localparam int unsigned SP_CLK_KEEP_BIT = 4;
    localparam int unsigned SP_RESV_BIT = 3;
    localparam int unsigned SP_3D_BIT = 2;

    // dac routing codes
    typedef enum logic [1:0] {
        CCPC_ROUTE_MUTE = 2'h0,
        CCPC_ROUTE_SAME = 2'h1,
        CCPC_ROUTE_SWAP = 2'h2,
        CCPC_ROUTE_MONO = 2'h3
    } ccpc_route_t;

    // ========================================================
    // serial clock generation
    localparam int unsigned SAMPLE_W = 16;
    localparam logic [7:0] BCLK_HALF_CYCLES = 8'h04;
    localparam logic [4:0] BCLK_PER_WCLK_HALF = 5'h1f;

    // ========================================================
    // controller wishbone map
    localparam logic [3:0] WB_CMD = 4'h0;
    localparam logic [3:0] WB_FRACTION = 4'h4;
    localparam logic [3:0] WB_STATUS = 4'h8;
    localparam int unsigned CMD_WE_BIT = 15;
    localparam int unsigned CMD_ADDR_LSB = 8;
    localparam int unsigned ST_BUSY_BIT = 9;
    localparam int unsigned ST_ERR_BIT = 8;

endpackage : ccpc_pkg

// ===== verilog/ccpc_link_if.sv
// register link between the controller and the codec register bank
`timescale 1ns/1ps
`default_nettype none
interface ccpc_link_if;
    logic       req;
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;

    modport device (
        input  req,
        input  we,
        input  addr,
        input  wdata,
        output ack,
        output rdata
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input  ack,
        input  rdata
    );
endinterface : ccpc_link_if
`default_nettype wire

// ===== verilog/ccpc_device.sv
// codec clock path register bank: pll fraction, data path and serial port control
//
// Contract
// - high register holds fraction bits 13..6
// - low register bits 7..2, bits 1..0 zero
// - host writes fraction values up to 9999
// - host writes high then low, always both
// - bit 7 picks 48 or 44.1 kHz
// - dual rate bits; host keeps them equal
// - left dac route: mute, left, right, mono
// - right dac route: mute, right, left, mono
// - host writes zero to setup bit 0
// - bit 7 sets bit clock direction
// - bit 6 sets word clock direction
// - bit 5 floats idle serial output
// - bit 4 keeps master clocks when powered down
// - bit 2 enables 3-d effect
// - host leaves bit 3, zeros bits 1..0; the host writes bit 3 as zero too
// - page 0 active after reset
// - all registers eight bits wide
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ccpc_device (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    ccpc_link_if.device       link,
    input  wire logic         powered_down_i,
    input  wire logic [15:0]  sample_left_i,
    input  wire logic [15:0]  sample_right_i,
    input  wire logic         dout_data_i,
    input  wire logic         dout_valid_i,
    input  wire logic         bclk_i,
    input  wire logic         wclk_i,
    output logic [13:0]       pll_fraction_o,
    output logic              reference_sample_rate_o,
    output logic              adc_dual_rate_o,
    output logic              dac_dual_rate_o,
    output logic [15:0]       dac_left_o,
    output logic [15:0]       dac_right_o,
    output logic              effect_3d_o,
    output logic              bclk_o,
    output logic              bclk_oe_o,
    output logic              wclk_o,
    output logic              wclk_oe_o,
    output logic              codec_bclk_o,
    output logic              codec_wclk_o,
    output logic              dout_o,
    output logic              dout_oe_o
);

    // ========================================================
    // register storage
    logic [7:0] page_reg;
    logic [7:0] frac_high_reg;
    logic [5:0] frac_low_reg;
    logic [7:0] datapath_reg;
    logic [7:0] serial_a_reg;
    logic       ack_reg;
    logic [7:0] rdata_reg;
    logic       wr_go;
    logic       rd_go;
    logic       page0;
    logic [7:0] div_reg;
    logic [4:0] wcnt_reg;
    logic       clk_run;

    // route one dac channel from its own and the other input
    function automatic logic [15:0] route_sample(
        input logic [1:0]  mode,
        input logic [15:0] own,
        input logic [15:0] other
    );
        logic [16:0] sum;
        sum = {own[15], own} + {other[15], other};
        case (mode)
            ccpc_pkg::CCPC_ROUTE_SAME: route_sample = own;
            ccpc_pkg::CCPC_ROUTE_SWAP: route_sample = other;
            ccpc_pkg::CCPC_ROUTE_MONO: route_sample = sum[16:1];
            default:                   route_sample = 16'h0000;
        endcase
    endfunction : route_sample

    // one access per request, none while ack stands
    assign wr_go = link.req && link.we && !ack_reg;
    assign rd_go = link.req && !link.we && !ack_reg;
    assign page0 = (page_reg[0] == 1'b0);

    // ========================================================
    // link answer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= link.req && !ack_reg;
    end

    // read data, eight bits per register, unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_reg <= ccpc_pkg::RESET_BYTE;
        else if (rd_go)
        begin
            rdata_reg <= ccpc_pkg::RESET_BYTE;
            if (link.addr == ccpc_pkg::REG_PAGE_SELECT)
                rdata_reg <= page_reg;
            else if (page0)
            begin
                case (link.addr)
                    ccpc_pkg::REG_PLL_FRACTION_HIGH:
                        rdata_reg <= frac_high_reg;
                    ccpc_pkg::REG_PLL_FRACTION_LOW:
                        rdata_reg <= {frac_low_reg, 2'b00};
                    ccpc_pkg::REG_CODEC_DATAPATH_SETUP:
                        rdata_reg <= datapath_reg;
                    ccpc_pkg::REG_SERIAL_PORT_CONTROL_A:
                        rdata_reg <= serial_a_reg;
                    default:
                        rdata_reg <= ccpc_pkg::RESET_BYTE;
                endcase
            end
        end
    end

    assign link.ack   = ack_reg;
    assign link.rdata = rdata_reg;

    // ========================================================
    // page selector, page 0 after reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            page_reg <= ccpc_pkg::RESET_BYTE;
        else if (wr_go && link.addr == ccpc_pkg::REG_PAGE_SELECT)
            page_reg <= {7'h00, link.wdata[0]};
    end

    // fraction high byte
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            frac_high_reg <= ccpc_pkg::RESET_BYTE;
        else if (wr_go && page0 && link.addr == ccpc_pkg::REG_PLL_FRACTION_HIGH)
            frac_high_reg <= link.wdata;
    end

    // fraction low six bits, reserved bits not stored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            frac_low_reg <= 6'h00;
        else if (wr_go && page0 && link.addr == ccpc_pkg::REG_PLL_FRACTION_LOW)
            frac_low_reg <= link.wdata[7:ccpc_pkg::FRAC_LOW_LSB];
    end

    // fraction reaches the pll only on the low byte write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pll_fraction_o <= 14'h0000;
        else if (wr_go && page0 && link.addr == ccpc_pkg::REG_PLL_FRACTION_LOW)
            pll_fraction_o <= {frac_high_reg, link.wdata[7:2]};
    end

    // data path setup, all bits stored as written
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            datapath_reg <= ccpc_pkg::RESET_BYTE;
        else if (wr_go && page0 && link.addr == ccpc_pkg::REG_CODEC_DATAPATH_SETUP)
            datapath_reg <= link.wdata;
    end

    // serial port control a
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            serial_a_reg <= ccpc_pkg::RESET_BYTE;
        else if (wr_go && page0 && link.addr == ccpc_pkg::REG_SERIAL_PORT_CONTROL_A)
            serial_a_reg <= link.wdata;
    end

    // ========================================================
    // data path controls
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reference_sample_rate_o <= 1'b0;
            adc_dual_rate_o         <= 1'b0;
            dac_dual_rate_o         <= 1'b0;
            effect_3d_o             <= 1'b0;
        end
        else
        begin
            reference_sample_rate_o <= datapath_reg[ccpc_pkg::DP_REF_RATE_BIT];
            adc_dual_rate_o <= datapath_reg[ccpc_pkg::DP_ADC_DUAL_BIT];
            dac_dual_rate_o <= datapath_reg[ccpc_pkg::DP_DAC_DUAL_BIT];
            effect_3d_o     <= serial_a_reg[ccpc_pkg::SP_3D_BIT];
        end
    end

    // dac channel routing
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dac_left_o  <= 16'h0000;
            dac_right_o <= 16'h0000;
        end
        else
        begin
            dac_left_o  <= route_sample(datapath_reg[4:3],
                                        sample_left_i, sample_right_i);
            dac_right_o <= route_sample(datapath_reg[2:1],
                                        sample_right_i, sample_left_i);
        end
    end

    // ========================================================
    // master clocks run while bit 7 or bit 6 drives a clock, unless powered down without keep
    assign clk_run = (serial_a_reg[ccpc_pkg::SP_BCLK_DIR_BIT]
                      || serial_a_reg[ccpc_pkg::SP_WCLK_DIR_BIT])
                     && (!powered_down_i
                         || serial_a_reg[ccpc_pkg::SP_CLK_KEEP_BIT]);

    // bit clock divider
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_reg <= 8'h00;
            bclk_o  <= 1'b0;
        end
        else if (clk_run)
        begin
            if (div_reg == ccpc_pkg::BCLK_HALF_CYCLES - 8'h01)
            begin
                div_reg <= 8'h00;
                bclk_o  <= !bclk_o;
            end
            else
                div_reg <= div_reg + 8'h01;
        end
    end

    // word clock from bit clock falling edges
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wcnt_reg <= 5'h00;
            wclk_o   <= 1'b0;
        end
        else if (clk_run && bclk_o
                 && div_reg == ccpc_pkg::BCLK_HALF_CYCLES - 8'h01)
        begin
            wcnt_reg <= wcnt_reg + 5'h01;
            if (wcnt_reg == ccpc_pkg::BCLK_PER_WCLK_HALF)
                wclk_o <= !wclk_o;
        end
    end

    // pin directions and clocks seen by the codec
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bclk_oe_o    <= 1'b0;
            wclk_oe_o    <= 1'b0;
            codec_bclk_o <= 1'b0;
            codec_wclk_o <= 1'b0;
        end
        else
        begin
            bclk_oe_o <= serial_a_reg[ccpc_pkg::SP_BCLK_DIR_BIT];
            wclk_oe_o <= serial_a_reg[ccpc_pkg::SP_WCLK_DIR_BIT];
            codec_bclk_o <= serial_a_reg[ccpc_pkg::SP_BCLK_DIR_BIT] ? bclk_o : bclk_i;
            codec_wclk_o <= serial_a_reg[ccpc_pkg::SP_WCLK_DIR_BIT] ? wclk_o : wclk_i;
        end
    end

    // serial data out, floated when idle if asked
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dout_o    <= 1'b0;
            dout_oe_o <= 1'b1;
        end
        else
        begin
            dout_o    <= dout_data_i;
            dout_oe_o <= !serial_a_reg[ccpc_pkg::SP_DOUT_TRI_BIT] || dout_valid_i;
        end
    end

endmodule : ccpc_device
`default_nettype wire

// ===== verilog/ccpc_host.sv
// controller end: wishbone slave that issues register link accesses
`timescale 1ns/1ps
`default_nettype none
module ccpc_host (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    ccpc_link_if.host         link,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [3:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic [31:0]       wb_dat_o,
    output logic              wb_ack_o
);

    // link sequencer states
    typedef enum logic [2:0] {
        CCPC_IDLE = 3'b001,
        CCPC_SEND = 3'b010,
        CCPC_GAP  = 3'b100
    } ccpc_state_t;

    ccpc_state_t state_reg;
    logic        req_reg;
    logic        we_reg;
    logic [6:0]  addr_reg;
    logic [7:0]  wdata_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  low_pend_reg;
    logic        second_reg;
    logic        err_reg;
    logic        wb_go;
    logic        wr_cmd;
    logic        wr_frac;
    logic        busy;
    logic        frac_bad;
    logic        cmd_bad;
    logic [6:0]  cmd_addr;

    // force reserved and paired bits to legal values
    function automatic logic [7:0] clean_byte(
        input logic [6:0] a,
        input logic [7:0] d
    );
        clean_byte = d;
        if (a == ccpc_pkg::REG_CODEC_DATAPATH_SETUP)
        begin
            clean_byte[ccpc_pkg::DP_RESV_BIT] = 1'b0;
            clean_byte[ccpc_pkg::DP_ADC_DUAL_BIT] = d[ccpc_pkg::DP_DAC_DUAL_BIT];
        end
        if (a == ccpc_pkg::REG_SERIAL_PORT_CONTROL_A)
            clean_byte = {d[7:4], 1'b0, d[2], 2'b00};
    endfunction : clean_byte

    // ========================================================
    // wishbone decode
    assign wb_go    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busy     = (state_reg != CCPC_IDLE);
    assign cmd_addr = wb_dat_i[14:8];
    assign wr_cmd   = wb_go && wb_we_i && wb_adr_i == ccpc_pkg::WB_CMD && wb_sel_i[1];
    assign wr_frac  = wb_go && wb_we_i && wb_adr_i == ccpc_pkg::WB_FRACTION && wb_sel_i[1];
    assign frac_bad = wb_dat_i[13:0] > ccpc_pkg::FRAC_MAX;
    assign cmd_bad  = wb_dat_i[ccpc_pkg::CMD_WE_BIT]
                      && (cmd_addr == ccpc_pkg::REG_PLL_FRACTION_HIGH
                          || cmd_addr == ccpc_pkg::REG_PLL_FRACTION_LOW);

    // ack one cycle after the strobe, dropped the next
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_go;
    end

    // read data, unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_go && !wb_we_i)
            wb_dat_o <= (wb_adr_i == ccpc_pkg::WB_STATUS)
                        ? {22'h00_0000, busy, err_reg, rdata_reg} : 32'h0000_0000;
    end

    // sticky error, a new refusal wins over the clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            err_reg <= 1'b0;
        else if ((wr_cmd && (busy || cmd_bad)) || (wr_frac && (busy || frac_bad)))
            err_reg <= 1'b1;
        else if (wb_go && wb_we_i && wb_adr_i == ccpc_pkg::WB_STATUS
                 && wb_sel_i[1] && wb_dat_i[ccpc_pkg::ST_ERR_BIT])
            err_reg <= 1'b0;
    end

    // ========================================================
    // link sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg    <= CCPC_IDLE;
            req_reg      <= 1'b0;
            we_reg       <= 1'b0;
            addr_reg     <= 7'h00;
            wdata_reg    <= 8'h00;
            rdata_reg    <= 8'h00;
            low_pend_reg <= 8'h00;
            second_reg   <= 1'b0;
        end
        else
        begin
            case (state_reg)
                CCPC_IDLE:
                begin
                    if (wr_cmd && !cmd_bad)
                    begin
                        req_reg   <= 1'b1;
                        we_reg    <= wb_dat_i[ccpc_pkg::CMD_WE_BIT];
                        addr_reg  <= cmd_addr;
                        wdata_reg <= clean_byte(cmd_addr, wb_dat_i[7:0]);
                        state_reg <= CCPC_SEND;
                    end
                    else if (wr_frac && !frac_bad)
                    begin
                        req_reg      <= 1'b1;
                        we_reg       <= 1'b1;
                        addr_reg     <= ccpc_pkg::REG_PLL_FRACTION_HIGH;
                        wdata_reg    <= wb_dat_i[13:6];
                        low_pend_reg <= {wb_dat_i[5:0], 2'b00};
                        second_reg   <= 1'b1;
                        state_reg    <= CCPC_SEND;
                    end
                end
                CCPC_SEND:
                begin
                    if (link.ack)
                    begin
                        req_reg   <= 1'b0;
                        rdata_reg <= we_reg ? rdata_reg : link.rdata;
                        state_reg <= CCPC_GAP;
                    end
                end
                CCPC_GAP:
                begin
                    if (second_reg)
                    begin
                        req_reg    <= 1'b1;
                        addr_reg   <= ccpc_pkg::REG_PLL_FRACTION_LOW;
                        wdata_reg  <= low_pend_reg;
                        second_reg <= 1'b0;
                        state_reg  <= CCPC_SEND;
                    end
                    else
                        state_reg <= CCPC_IDLE;
                end
                default:
                    state_reg <= CCPC_IDLE;
            endcase
        end
    end

    assign link.req   = req_reg;
    assign link.we    = we_reg;
    assign link.addr  = addr_reg;
    assign link.wdata = wdata_reg;

endmodule : ccpc_host
`default_nettype wire

// ===== verification/ccpc_sva.sv
// assertions on the register link between controller and register bank
`timescale 1ns/1ps
`default_nettype none
module ccpc_sva (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       req,
    input wire logic       we,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata
);
    // ==========================================================
    // shadow of the active page and the four registers
    logic [7:0] sh_reg [5:8];
    logic       page_reg;
    logic       take;
    assign take = req && !ack && we;

    // follow writes at the edge they are taken
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            page_reg <= 1'b0;
            for (int i = 5; i < 9; i++)
                sh_reg[i] <= 8'h00;
        end
        else if (take && addr == ccpc_pkg::REG_PAGE_SELECT)
            page_reg <= wdata[0];
        else if (take && !page_reg && addr >= 7'h05 && addr <= 7'h08)
            sh_reg[addr] <= (addr == 7'h06) ? (wdata & 8'hfc) : wdata;
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_pulse;
        req && !ack |=> ack ##1 !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("link answer not a single cycle pulse");
    property p_req_hold;
        req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("link request changed before answer");
    property p_req_drop;
        ack |=> !req;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("link request still high after answer");
    property p_rd_bank;
        ack && !we && addr inside {[7'h05:7'h08]} |-> rdata == (page_reg ? 8'h00 : sh_reg[addr]);
    endproperty
    a_rd_bank: assert property (p_rd_bank)
        else $error("register read differs from last write");
    property p_rd_low;
        ack && !we && addr == 7'h06 |-> rdata[1:0] == 2'b00;
    endproperty
    a_rd_low: assert property (p_rd_low)
        else $error("fraction low reserved bits not zero");
    property p_rd_page;
        ack && !we && addr == 7'h00 |-> rdata == {7'h00, page_reg};
    endproperty
    a_rd_page: assert property (p_rd_page)
        else $error("page select read wrong");
    property p_wr_setup;
        req && we && addr == 7'h07 |-> !wdata[0] && wdata[6] == wdata[5];
    endproperty
    a_wr_setup: assert property (p_wr_setup)
        else $error("setup write with bad reserved or dual rate bits");
    property p_wr_serial;
        req && we && addr == 7'h08 |-> wdata[3] == 1'b0 && wdata[1:0] == 2'b00;
    endproperty
    a_wr_serial: assert property (p_wr_serial)
        else $error("serial control write touches reserved bits");
    property p_frac_order;
        ack && we && addr == 7'h05 |-> ##[1:8] (req && we && addr == 7'h06);
    endproperty
    a_frac_order: assert property (p_frac_order)
        else $error("fraction high write not followed by low write");
    property p_frac_range;
        req && we && addr == 7'h06 |-> {sh_reg[5], wdata[7:2]} <= ccpc_pkg::FRAC_MAX;
    endproperty
    a_frac_range: assert property (p_frac_range)
        else $error("fraction above limit written");
endmodule : ccpc_sva
`default_nettype wire

// ===== verification/testbench.sv
// self-checking testbench joining controller and register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, pdn, dval, ddat, q_b;
    logic [3:0]  wb_adr;
    logic [31:0] wb_dat, wb_q, s;
    logic [13:0] frac;
    logic        ref_rate, adc_dual, dac_dual, fx3d, bclk, bclk_oe, wclk_oe, dout, dout_oe;
    logic [15:0] dac_l, dac_r;
    logic [7:0]  q;
    int          fail_count, cmp_count, cycles, t;

    ccpc_link_if link ();
    ccpc_device ccpc_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .powered_down_i(pdn), .sample_left_i(16'h1000), .sample_right_i(16'h0200),
        .dout_data_i(ddat), .dout_valid_i(dval), .bclk_i(1'b0), .wclk_i(1'b0),
        .pll_fraction_o(frac), .reference_sample_rate_o(ref_rate),
        .adc_dual_rate_o(adc_dual), .dac_dual_rate_o(dac_dual), .dac_left_o(dac_l),
        .dac_right_o(dac_r), .effect_3d_o(fx3d), .bclk_o(bclk), .bclk_oe_o(bclk_oe),
        .wclk_o(), .wclk_oe_o(wclk_oe), .codec_bclk_o(), .codec_wclk_o(), .dout_o(dout),
        .dout_oe_o(dout_oe));
    ccpc_host ccpc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack));
    ccpc_sva ccpc_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

    // ==========================================================
    // clock and hang guard
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            close_out();
        end
    end

    // ==========================================================
    // bus tasks
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        s = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb
    task automatic idle();
        do wb(1'b0, ccpc_pkg::WB_STATUS, 32'h0); while (s[ccpc_pkg::ST_BUSY_BIT] !== 1'b0);
        q = s[7:0];
    endtask : idle
    task automatic lk(input logic w, input logic [6:0] a, input logic [7:0] d);
        wb(1'b1, ccpc_pkg::WB_CMD, {16'h0000, w, a, d});
        idle();
    endtask : lk
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            $display("BAD at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask : chk
    task automatic toggles();
        t = 0;
        q_b = bclk;
        repeat (24) @(negedge clk_i)
        begin
            if (bclk !== q_b)
                t++;
            q_b = bclk;
        end
    endtask : toggles
    function automatic logic [15:0] route(input logic [1:0] m, input logic [15:0] o,
                                          input logic [15:0] x);
        logic [16:0] sum;
        sum = {o[15], o} + {x[15], x};
        return (m == 2'h0) ? 16'h0000 : (m == 2'h1) ? o : (m == 2'h2) ? x : sum[16:1];
    endfunction : route
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    // ==========================================================
    // test sequence
    initial
    begin
        {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, pdn, dval, ddat} = {1'b1, 42'h0};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 9; a += (a == 0) ? 5 : 1)
        begin
            lk(1'b0, a[6:0], 8'h00);
            chk(q, 32'h0);
        end
        chk(frac, 32'h0);
        $display("test reset done");
        wb(1'b1, ccpc_pkg::WB_FRACTION, 32'd9999);
        idle();
        chk(frac, ccpc_pkg::FRAC_MAX);
        lk(1'b0, 7'h05, 8'h00);
        chk(q, 32'h9c);
        lk(1'b0, 7'h06, 8'h00);
        chk(q, 32'h3c);
        wb(1'b1, ccpc_pkg::WB_FRACTION, 32'd10000);
        idle();
        chk({s[8], 17'h0, frac}, {1'b1, 17'h0, ccpc_pkg::FRAC_MAX});
        wb(1'b1, ccpc_pkg::WB_STATUS, 32'h100);
        lk(1'b1, 7'h05, 8'h11);
        chk(s[8], 32'h1);
        wb(1'b1, ccpc_pkg::WB_STATUS, 32'h100);
        $display("test fraction done");
        for (int m = 0; m < 4; m++)
        begin
            lk(1'b1, 7'h07, {3'b000, m[1:0], m[1:0], 1'b0});
            chk(dac_l, route(m[1:0], 16'h1000, 16'h0200));
            chk(dac_r, route(m[1:0], 16'h0200, 16'h1000));
        end
        lk(1'b1, 7'h07, 8'ha1);
        lk(1'b0, 7'h07, 8'h00);
        chk({q, ref_rate, adc_dual, dac_dual}, {8'he0, 3'b111});
        lk(1'b1, 7'h07, 8'h40);
        lk(1'b0, 7'h07, 8'h00);
        chk({q, ref_rate, adc_dual, dac_dual}, 32'h0);
        $display("test datapath done");
        lk(1'b1, 7'h08, 8'hfb);
        lk(1'b0, 7'h08, 8'h00);
        chk({q, bclk_oe, wclk_oe, fx3d}, {8'hf0, 3'b110});
        lk(1'b1, 7'h08, 8'h34);
        chk({bclk_oe, wclk_oe, fx3d, dout_oe}, 4'b0010);
        dval <= 1'b1;
        ddat <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({dout, dout_oe}, 2'b11);
        pdn  <= 1'b1;
        dval <= 1'b0;
        lk(1'b1, 7'h08, 8'hc0);
        toggles();
        chk({t != 0, dout_oe}, 2'b01);
        lk(1'b1, 7'h08, 8'hd0);
        toggles();
        chk(t != 0, 32'h1);
        $display("test serial port done");
        lk(1'b1, 7'h00, 8'h01);
        lk(1'b0, 7'h05, 8'h00);
        chk(q, 32'h0);
        lk(1'b1, 7'h00, 8'h00);
        lk(1'b0, 7'h05, 8'h00);
        chk(q, 32'h9c);
        $display("test page done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
